// >>> core/smcg_cfg.svh
// Purpose: Named constants of the sleep-mode clock gating block
// Assumes: Included by every design file of the block
// Notes:   Start-up counts are plain defaults, one per clock-select fuse code
`ifndef SMCG_CFG_SVH
`define SMCG_CFG_SVH

// ============================================================
// Sleep mode select encodings
`define SMCG_MODE_IDLE   3'h0
`define SMCG_MODE_ADCNR  3'h1
`define SMCG_MODE_PDOWN  3'h2
`define SMCG_MODE_PSAVE  3'h3
`define SMCG_MODE_STBY   3'h6
`define SMCG_MODE_XSTBY  3'h7

// ============================================================
// Wake-up timing in SYS_CLK cycles
`define SMCG_CNT_W           12
`define SMCG_HALT_LAST       3'h3
`define SMCG_HALT_ZERO       3'h0
`define SMCG_HALT_STEP       3'h1
`define SMCG_CNT_ONE         12'h001
`define SMCG_CLOCK_RUN_WAKE  12'h001
`define SMCG_STBY_WAKE       12'h006
`define SMCG_STARTUP_CYC0    12'h010
`define SMCG_STARTUP_CYC1    12'h040
`define SMCG_STARTUP_CYC2    12'h100
`define SMCG_STARTUP_CYC3    12'h400
`define SMCG_FUSE_CODE0      2'h0
`define SMCG_FUSE_CODE1      2'h1
`define SMCG_FUSE_CODE2      2'h2

// ============================================================
// Pin groups
`define SMCG_IRQ_LINES   8
`define SMCG_LOWER_MSB   3
`define SMCG_UPPER_LSB   4

`endif

// >>> core/smcg_pkg.sv
// Purpose: Types of the sleep-mode clock gating block
// Assumes: smcg_cfg.svh gives the widths
// Notes:   All state of each module is one packed struct
`include "smcg_cfg.svh"

package smcg_pkg;

  // ============================================================
  // Controller states
  typedef enum logic [1:0] {
    SMCG_ST_ACTIVE = 2'h0,
    SMCG_ST_SLEEP  = 2'h1,
    SMCG_ST_START  = 2'h2,
    SMCG_ST_HALT   = 2'h3
  } smcg_state_e;

  // ============================================================
  // Wake delay counter state
  typedef struct packed {
    logic [`SMCG_CNT_W-1:0] cnt;
    logic                   run;
    logic                   done;
  } smcg_cnt_s;

  // ============================================================
  // Top controller state
  typedef struct packed {
    smcg_state_e                 st;
    logic [2:0]                  mode;
    logic [2:0]                  halt_cnt;
    logic [`SMCG_IRQ_LINES-1:0]  sync1;
    logic [`SMCG_IRQ_LINES-1:0]  sync2;
    logic [`SMCG_IRQ_LINES-1:0]  prev;
    logic                        adc_en_prev;
    logic                        load;
    logic [`SMCG_CNT_W-1:0]      count;
    logic                        core_clk;
    logic                        flash_clk;
    logic                        io_clk;
    logic                        adc_clk;
    logic                        async_clk;
    logic                        main_osc;
    logic                        timer_osc;
    logic                        adc_start;
    logic                        adc_ext;
    logic                        comp_pwr;
    logic                        vref;
    logic                        bod;
    logic                        wdt;
    logic                        inbuf;
    logic [`SMCG_IRQ_LINES-1:0]  pinbuf;
    logic                        sleeping;
    logic                        halt;
    logic                        wake_irq;
    logic                        wake_rst;
    logic                        undef;
    logic                        refused;
  } smcg_top_s;

endpackage

// >>> core/smcg_top.sv
// Purpose: Sleep mode decode, clock gating, wake source filter, wake delay
// Assumes: Core and interrupt inputs are on SYS_CLK; irq lines are pins
// Notes:   Outputs are enables for the clock gates and analogue blocks, ADC start controls and sleep, halt, wake status flags
//
// Behaviour
// R1: Sleep needs enable bit plus sleep instruction
// R2: Core halted four cycles after start-up
// R3: Idle stops only core and flash clocks
// R4: Idle wakes on any enabled interrupt
// R5: Comparator disable bit removes comparator wake
// R6: Idle or noise mode starts ADC conversion
// R7: Noise mode stops io, core, flash clocks
// R8: Noise mode wakes only on listed sources
// R9: Power-down stops oscillator and generated clocks
// R10: Power-down wakes only on listed sources
// R11: Level wake source must hold its level
// R12: Power-down wake waits fuse start-up period
// R13: Power-save keeps async clock when selected
// R14: Power-save wakes on enabled timer0 events
// R15: Async registers undefined without async select
// R16: Standby keeps oscillator, wakes in six cycles
// R17: Extended standby is power-save plus oscillator
// R18: Reserved mode codes enter no sleep
// R19: ADC stays on; re-enable forces extended conversion
// R20: Deep modes turn comparator off unless reference
// R21: Reference on while BOD, comparator or ADC
// R22: Fuse-enabled brown-out detector never gated
// R23: Enabled watchdog keeps running in sleep
// R24: Deep modes disable input buffers except wake pins
`timescale 1ns/1ps
`include "smcg_cfg.svh"

module smcg_top (
  input  wire logic                        SYS_CLK,
  input  wire logic                        RESETN,
  input  wire logic                        CLK_EN,
  input  wire logic                        SLEEP_EXEC,
  input  wire logic                        SLEEP_ENABLE_BIT,
  input  wire logic [2:0]                  SLEEP_MODE_SELECT,
  input  wire logic                        XTAL_SELECTED,
  input  wire logic [1:0]                  CLOCK_SELECT_FUSE,
  input  wire logic [`SMCG_LOWER_MSB:0]    LOWER_EXT_IRQ_LINES,
  input  wire logic [`SMCG_LOWER_MSB:0]    UPPER_EXT_IRQ_LINES,
  input  wire logic [`SMCG_IRQ_LINES-1:0]  EXT_IRQ_ENABLE,
  input  wire logic [`SMCG_LOWER_MSB:0]    UPPER_LEVEL_MODE,
  input  wire logic                        IRQ_ANY_ENABLED,
  input  wire logic                        IRQ_COMPARATOR,
  input  wire logic                        IRQ_ADC_DONE,
  input  wire logic                        IRQ_TWI_MATCH,
  input  wire logic                        IRQ_SPM_EE_READY,
  input  wire logic                        TIMER0_OVF_EVENT,
  input  wire logic                        TIMER0_CMP_EVENT,
  input  wire logic                        TIMER0_OVF_IE,
  input  wire logic                        TIMER0_CMP_IE,
  input  wire logic                        GLOBAL_IE,
  input  wire logic                        TIMER0_ASYNC_SELECT,
  input  wire logic                        EXT_RESET_REQ,
  input  wire logic                        WDT_RESET_REQ,
  input  wire logic                        BOD_RESET_REQ,
  input  wire logic                        COMPARATOR_DISABLE,
  input  wire logic                        COMPARATOR_USES_VREF,
  input  wire logic                        ADC_ENABLE,
  input  wire logic                        ADC_CONV_STARTED,
  input  wire logic                        BROWNOUT_ENABLE_FUSE,
  input  wire logic                        WDT_ENABLE,
  output logic                             CORE_CLOCK_EN,
  output logic                             PROGRAM_MEM_CLOCK_EN,
  output logic                             PERIPHERAL_IO_CLOCK_EN,
  output logic                             CONVERTER_CLOCK_EN,
  output logic                             ASYNC_CLOCK_EN,
  output logic                             MAIN_OSC_EN,
  output logic                             TIMER_OSC_EN,
  output logic                             ADC_AUTO_START,
  output logic                             ADC_EXTENDED_NEXT,
  output logic                             COMPARATOR_POWER_EN,
  output logic                             VREF_EN,
  output logic                             BOD_ACTIVE,
  output logic                             WDT_RUN,
  output logic                             INPUT_BUF_EN,
  output logic [`SMCG_IRQ_LINES-1:0]       WAKE_PIN_BUF_EN,
  output logic                             SLEEPING,
  output logic                             CORE_HALT,
  output logic                             WAKE_IRQ,
  output logic                             WAKE_RESET,
  output logic                             ASYNC_REGS_UNDEFINED,
  output logic                             MODE_REFUSED
);

  smcg_pkg::smcg_top_s q;
  smcg_pkg::smcg_top_s d;
  smcg_wake_if         wk ();

  logic [`SMCG_LOWER_MSB:0] lo_now;
  logic [`SMCG_LOWER_MSB:0] lo_old;
  logic [`SMCG_LOWER_MSB:0] up_now;
  logic                     ext_lim;
  logic                     t0_wake;
  logic                     rst_wake;
  logic                     irq_wake;
  logic                     mode_ok;
  logic                     deep;
  logic [`SMCG_CNT_W-1:0]   fuse_cyc;

  // ============================================================
  // Wake source filter
  always_comb begin
    lo_now = q.sync2[`SMCG_LOWER_MSB:0];
    lo_old = q.prev[`SMCG_LOWER_MSB:0];
    up_now = q.sync2[`SMCG_IRQ_LINES-1:`SMCG_UPPER_LSB];
    // R11: level seen only after two sync stages
    // R8: lower lines any edge or low, upper lines low level only
    ext_lim = |(EXT_IRQ_ENABLE[`SMCG_LOWER_MSB:0] & (~lo_now | (lo_now ^ lo_old)))
            | |(EXT_IRQ_ENABLE[`SMCG_IRQ_LINES-1:`SMCG_UPPER_LSB] & UPPER_LEVEL_MODE
                & ~up_now);
    // R14: timer0 wake needs its enable and global enable
    t0_wake = GLOBAL_IE & ((TIMER0_OVF_EVENT & TIMER0_OVF_IE)
                         | (TIMER0_CMP_EVENT & TIMER0_CMP_IE));
    rst_wake = EXT_RESET_REQ | WDT_RESET_REQ | BOD_RESET_REQ;
    irq_wake = 1'b0;
    case (q.mode)
      // R4: any enabled interrupt
      // R5: comparator wake dropped when disabled
      `SMCG_MODE_IDLE:  irq_wake = IRQ_ANY_ENABLED | ext_lim
                                 | (IRQ_COMPARATOR & ~COMPARATOR_DISABLE);
      // R8: noise reduction wake set
      `SMCG_MODE_ADCNR: irq_wake = IRQ_ADC_DONE | IRQ_TWI_MATCH | t0_wake
                                 | IRQ_SPM_EE_READY | ext_lim;
      // R14: timer0 only while it runs asynchronously
      `SMCG_MODE_PSAVE,
      `SMCG_MODE_XSTBY: irq_wake = IRQ_TWI_MATCH | ext_lim
                                 | (t0_wake & TIMER0_ASYNC_SELECT);
      // R10: power-down and standby wake set
      default:          irq_wake = IRQ_TWI_MATCH | ext_lim;
    endcase
  end

  // ============================================================
  // Mode legality and start-up length
  always_comb begin
    // R18: reserved codes, and standby codes without a crystal
    case (SLEEP_MODE_SELECT)
      `SMCG_MODE_IDLE,
      `SMCG_MODE_ADCNR,
      `SMCG_MODE_PDOWN,
      `SMCG_MODE_PSAVE: mode_ok = 1'b1;
      `SMCG_MODE_STBY,
      `SMCG_MODE_XSTBY: mode_ok = XTAL_SELECTED;
      default:          mode_ok = 1'b0;
    endcase
    // R12: same fuse code as the reset time-out
    if (CLOCK_SELECT_FUSE == `SMCG_FUSE_CODE0) begin
      fuse_cyc = `SMCG_STARTUP_CYC0;
    end else if (CLOCK_SELECT_FUSE == `SMCG_FUSE_CODE1) begin
      fuse_cyc = `SMCG_STARTUP_CYC1;
    end else if (CLOCK_SELECT_FUSE == `SMCG_FUSE_CODE2) begin
      fuse_cyc = `SMCG_STARTUP_CYC2;
    end else begin
      fuse_cyc = `SMCG_STARTUP_CYC3;
    end
  end

  // ============================================================
  // Controller next state
  always_comb begin
    d           = q;
    d.adc_start = 1'b0;
    d.wake_irq  = 1'b0;
    d.wake_rst  = 1'b0;
    d.refused   = 1'b0;
    d.load      = 1'b0;
    d.sync1     = {UPPER_EXT_IRQ_LINES, LOWER_EXT_IRQ_LINES};
    d.sync2     = q.sync1;
    d.prev      = q.sync2;
    d.adc_en_prev = ADC_ENABLE;
    // R19: re-enable marks next conversion extended, set beats clear
    if (ADC_CONV_STARTED) begin
      d.adc_ext = 1'b0;
    end
    if (ADC_ENABLE && !q.adc_en_prev) begin
      d.adc_ext = 1'b1;
    end
    case (q.st)
      smcg_pkg::SMCG_ST_ACTIVE: begin
        // R1: enable bit and sleep instruction together
        if (SLEEP_EXEC && SLEEP_ENABLE_BIT) begin
          if (mode_ok) begin
            d.st    = smcg_pkg::SMCG_ST_SLEEP;
            d.mode  = SLEEP_MODE_SELECT;
            d.undef = 1'b0;
            // R6: automatic conversion on entry
            d.adc_start = ADC_ENABLE && (SLEEP_MODE_SELECT == `SMCG_MODE_IDLE
                                      || SLEEP_MODE_SELECT == `SMCG_MODE_ADCNR);
          end else begin
            // R18: refused code is flagged, core keeps running
            d.refused = 1'b1;
          end
        end
      end
      smcg_pkg::SMCG_ST_SLEEP: begin
        if (rst_wake) begin
          d.st       = smcg_pkg::SMCG_ST_ACTIVE;
          d.wake_rst = 1'b1;
        end else if (irq_wake) begin
          d.st   = smcg_pkg::SMCG_ST_START;
          d.load = 1'b1;
          // R15: async timer contents not trusted after this wake
          d.undef = (q.mode == `SMCG_MODE_PSAVE || q.mode == `SMCG_MODE_XSTBY)
                    && !TIMER0_ASYNC_SELECT;
          // R12: stopped oscillator restarts for the fuse period
          // R16: oscillator kept running, short fixed wake
          // R17: same short wake for extended standby
          if (q.mode == `SMCG_MODE_PDOWN || q.mode == `SMCG_MODE_PSAVE) begin
            d.count = fuse_cyc;
          end else if (q.mode == `SMCG_MODE_STBY || q.mode == `SMCG_MODE_XSTBY) begin
            d.count = `SMCG_STBY_WAKE;
          end else begin
            d.count = `SMCG_CLOCK_RUN_WAKE;
          end
        end
      end
      smcg_pkg::SMCG_ST_START: begin
        if (wk.done) begin
          d.st       = smcg_pkg::SMCG_ST_HALT;
          d.halt_cnt = `SMCG_HALT_LAST;
        end
      end
      default: begin
        // R2: four halted cycles, then the handler runs
        if (q.halt_cnt == `SMCG_HALT_ZERO) begin
          d.st       = smcg_pkg::SMCG_ST_ACTIVE;
          d.wake_irq = 1'b1;
        end else begin
          d.halt_cnt = q.halt_cnt - `SMCG_HALT_STEP;
        end
      end
    endcase

    // Gating follows the next state so every output is a plain flop
    d.sleeping  = (d.st == smcg_pkg::SMCG_ST_SLEEP);
    d.halt      = (d.st == smcg_pkg::SMCG_ST_START) || (d.st == smcg_pkg::SMCG_ST_HALT);
    d.core_clk  = (d.st == smcg_pkg::SMCG_ST_ACTIVE);
    d.flash_clk = d.core_clk;
    d.io_clk    = 1'b1;
    d.adc_clk   = 1'b1;
    d.async_clk = 1'b1;
    d.main_osc  = 1'b1;
    d.timer_osc = TIMER0_ASYNC_SELECT;
    if (d.sleeping) begin
      case (d.mode)
        // R3: idle keeps everything but core and flash
        `SMCG_MODE_IDLE: begin
          d.io_clk = 1'b1;
        end
        // R7: noise reduction also stops the io clock
        `SMCG_MODE_ADCNR: begin
          d.io_clk = 1'b0;
        end
        // R13: power-save keeps async clock if selected
        // R17: extended standby adds the oscillator
        `SMCG_MODE_PSAVE,
        `SMCG_MODE_XSTBY: begin
          d.io_clk    = 1'b0;
          d.adc_clk   = 1'b0;
          d.async_clk = TIMER0_ASYNC_SELECT;
          d.main_osc  = (d.mode == `SMCG_MODE_XSTBY);
        end
        // R9: power-down stops all generated clocks
        // R16: standby keeps the oscillator only
        default: begin
          d.io_clk    = 1'b0;
          d.adc_clk   = 1'b0;
          d.async_clk = 1'b0;
          d.timer_osc = 1'b0;
          d.main_osc  = (d.mode == `SMCG_MODE_STBY);
        end
      endcase
    end
    deep = d.sleeping && d.mode != `SMCG_MODE_IDLE && d.mode != `SMCG_MODE_ADCNR;
    // R20: deep modes drop the comparator unless on the reference
    d.comp_pwr = !COMPARATOR_DISABLE && (!deep || COMPARATOR_USES_VREF);
    // R21: reference follows its three users
    d.vref     = BROWNOUT_ENABLE_FUSE || ADC_ENABLE || (d.comp_pwr && COMPARATOR_USES_VREF);
    // R22: fuse alone decides the detector
    d.bod      = BROWNOUT_ENABLE_FUSE;
    // R23: sleep never stops the watchdog
    d.wdt      = WDT_ENABLE;
    // R24: buffers off with io and ADC clocks, wake pins kept
    d.inbuf    = d.io_clk || d.adc_clk;
    d.pinbuf   = d.inbuf ? {`SMCG_IRQ_LINES{1'b1}} : EXT_IRQ_ENABLE;
  end

  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      q          <= '0;
      q.core_clk <= 1'b1;
      q.flash_clk <= 1'b1;
      q.io_clk   <= 1'b1;
      q.adc_clk  <= 1'b1;
      q.async_clk <= 1'b1;
      q.main_osc <= 1'b1;
      q.inbuf    <= 1'b1;
      q.pinbuf   <= {`SMCG_IRQ_LINES{1'b1}};
      // Lines idle high, so the synchroniser starts high to avoid a false edge
      q.sync1    <= {`SMCG_IRQ_LINES{1'b1}};
      q.sync2    <= {`SMCG_IRQ_LINES{1'b1}};
      q.prev     <= {`SMCG_IRQ_LINES{1'b1}};
      q.comp_pwr <= 1'b1;
      q.count    <= `SMCG_CLOCK_RUN_WAKE;
    end else if (CLK_EN) begin
      q <= d;
    end
  end

  assign wk.load  = q.load;
  assign wk.count = q.count;

  smcg_wake_delay u_delay (
    .clk   (SYS_CLK),
    .rst_n (RESETN),
    .ce    (CLK_EN),
    .wk    (wk.cnt)
  );

  assign CORE_CLOCK_EN          = q.core_clk;
  assign PROGRAM_MEM_CLOCK_EN   = q.flash_clk;
  assign PERIPHERAL_IO_CLOCK_EN = q.io_clk;
  assign CONVERTER_CLOCK_EN     = q.adc_clk;
  assign ASYNC_CLOCK_EN         = q.async_clk;
  assign MAIN_OSC_EN            = q.main_osc;
  assign TIMER_OSC_EN           = q.timer_osc;
  assign ADC_AUTO_START         = q.adc_start;
  assign ADC_EXTENDED_NEXT      = q.adc_ext;
  assign COMPARATOR_POWER_EN    = q.comp_pwr;
  assign VREF_EN                = q.vref;
  assign BOD_ACTIVE             = q.bod;
  assign WDT_RUN                = q.wdt;
  assign INPUT_BUF_EN           = q.inbuf;
  assign WAKE_PIN_BUF_EN        = q.pinbuf;
  assign SLEEPING               = q.sleeping;
  assign CORE_HALT              = q.halt;
  assign WAKE_IRQ               = q.wake_irq;
  assign WAKE_RESET             = q.wake_rst;
  assign ASYNC_REGS_UNDEFINED   = q.undef;
  assign MODE_REFUSED           = q.refused;

  // ============================================================
  // Checks
  a_sleep_needs_enable: assert property ( // R1
    @(posedge SYS_CLK) disable iff (!RESETN || !CLK_EN)
    (q.st == smcg_pkg::SMCG_ST_ACTIVE && SLEEP_EXEC && !SLEEP_ENABLE_BIT)
    |=> !SLEEPING) else $error("sleep entered without enable bit");
  a_halt_four_cycles: assert property ( // R2
    @(posedge SYS_CLK) disable iff (!RESETN || !CLK_EN)
    (q.st == smcg_pkg::SMCG_ST_START && wk.done)
    |=> (q.st == smcg_pkg::SMCG_ST_HALT && CORE_HALT)[*4] ##1 (WAKE_IRQ && CORE_CLOCK_EN))
    else $error("halt after start-up is not four cycles");
  a_idle_clock_set: assert property ( // R3
    @(posedge SYS_CLK) disable iff (!RESETN || !CLK_EN)
    (SLEEPING && q.mode == `SMCG_MODE_IDLE)
    |-> (!CORE_CLOCK_EN && !PROGRAM_MEM_CLOCK_EN && PERIPHERAL_IO_CLOCK_EN
         && CONVERTER_CLOCK_EN && MAIN_OSC_EN)) else $error("idle clock set wrong");
  a_adc_auto_start: assert property ( // R6
    @(posedge SYS_CLK) disable iff (!RESETN || !CLK_EN)
    (q.st == smcg_pkg::SMCG_ST_ACTIVE && SLEEP_EXEC && SLEEP_ENABLE_BIT && ADC_ENABLE
     && SLEEP_MODE_SELECT == `SMCG_MODE_ADCNR)
    |=> (ADC_AUTO_START && SLEEPING) ##1 !ADC_AUTO_START) else $error("no ADC auto start");
  a_noise_clock_set: assert property ( // R7
    @(posedge SYS_CLK) disable iff (!RESETN || !CLK_EN)
    (SLEEPING && q.mode == `SMCG_MODE_ADCNR)
    |-> (!PERIPHERAL_IO_CLOCK_EN && CONVERTER_CLOCK_EN && !CORE_CLOCK_EN))
    else $error("noise reduction clock set wrong");
  a_pdown_all_stop: assert property ( // R9
    @(posedge SYS_CLK) disable iff (!RESETN || !CLK_EN)
    (SLEEPING && q.mode == `SMCG_MODE_PDOWN)
    |-> (!MAIN_OSC_EN && !ASYNC_CLOCK_EN && !CONVERTER_CLOCK_EN && !INPUT_BUF_EN))
    else $error("power-down left a clock running");
  a_psave_async_clock: assert property ( // R13
    @(posedge SYS_CLK) disable iff (!RESETN || !CLK_EN)
    (SLEEPING && q.mode == `SMCG_MODE_PSAVE)
    |-> (ASYNC_CLOCK_EN == $past(TIMER0_ASYNC_SELECT) && !MAIN_OSC_EN))
    else $error("power-save async clock wrong");
  a_stby_six_cycles: assert property ( // R16
    @(posedge SYS_CLK) disable iff (!RESETN || !CLK_EN)
    (SLEEPING && q.mode == `SMCG_MODE_STBY && !rst_wake && irq_wake)
    |=> (CORE_HALT && MAIN_OSC_EN)[*8] ##1 CORE_HALT[*3] ##1 (WAKE_IRQ && !CORE_HALT))
    else $error("standby wake length wrong");
  a_reserved_refused: assert property ( // R18
    @(posedge SYS_CLK) disable iff (!RESETN || !CLK_EN)
    (q.st == smcg_pkg::SMCG_ST_ACTIVE && SLEEP_EXEC && SLEEP_ENABLE_BIT && !mode_ok)
    |=> (MODE_REFUSED && !SLEEPING && CORE_CLOCK_EN)) else $error("reserved mode entered");
  a_comp_deep_off: assert property ( // R20
    @(posedge SYS_CLK) disable iff (!RESETN || !CLK_EN)
    (SLEEPING && q.mode == `SMCG_MODE_PDOWN && !$past(COMPARATOR_USES_VREF))
    |-> !COMPARATOR_POWER_EN) else $error("comparator on in deep sleep");
  a_bod_not_gated: assert property ( // R22
    @(posedge SYS_CLK) disable iff (!RESETN || !CLK_EN)
    ($past(RESETN) && $past(BROWNOUT_ENABLE_FUSE)) |-> (BOD_ACTIVE && VREF_EN))
    else $error("detector gated");

endmodule // smcg_top

// >>> core/smcg_wake_delay.sv
// Purpose: Down counter timing the clock start-up after a wake event
// Assumes: Count loaded is at least one
// Notes:   Done is flopped beside the last count, so no cycle is lost
`timescale 1ns/1ps
`include "smcg_cfg.svh"

module smcg_wake_delay (
  input  wire logic  clk,
  input  wire logic  rst_n,
  input  wire logic  ce,
  smcg_wake_if.cnt   wk
);

  smcg_pkg::smcg_cnt_s q;
  smcg_pkg::smcg_cnt_s d;

  // ============================================================
  // Next state
  always_comb begin
    d = q;
    if (wk.load) begin
      d.cnt = wk.count;
      d.run = 1'b1;
    end else if (q.run) begin
      if (q.cnt == `SMCG_CNT_ONE) begin
        d.run = 1'b0;
      end else begin
        d.cnt = q.cnt - `SMCG_CNT_ONE;
      end
    end
    d.done = d.run && (d.cnt == `SMCG_CNT_ONE);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else if (ce) begin
      q <= d;
    end
  end

  assign wk.done = q.done;

endmodule // smcg_wake_delay

// >>> core/smcg_wake_if.sv
// Purpose: Carrier between the controller and its wake delay counter
// Assumes: Both ends run on SYS_CLK
// Notes:   Load is a one-cycle pulse with the count beside it
`timescale 1ns/1ps
`include "smcg_cfg.svh"

interface smcg_wake_if;
  logic                   load;
  logic [`SMCG_CNT_W-1:0] count;
  logic                   done;

  modport ctl (output load, output count, input done);
  modport cnt (input load, input count, output done);
endinterface

// >>> verif/smcg_core_model.sv
// Purpose: Core side that sets the enable bit, then executes sleep
// Assumes: Requests arrive at the falling edge
// Notes:   Enable bit leads the sleep pulse by one cycle
`timescale 1ns/1ps
// ==========
// Core model
module smcg_core_model (
  input  wire logic clk,
  input  wire logic req,
  input  wire logic no_en,
  output logic      sleep_exec,
  output logic      sleep_en
);
  initial {sleep_exec, sleep_en} = 2'h0;
  // enable then execute; no_en tries it without
  always @(negedge clk) begin
    sleep_exec <= (sleep_en | no_en) & req;
    sleep_en   <= req & ~no_en;
  end
endmodule // smcg_core_model

// >>> verif/smcg_top_test.sv
// Purpose: Self-checking bench of the sleep mode controller
// Assumes: Inputs change at the falling edge
// Notes:   Standby, power-down and power-save wakes are timed; fuse code stays 0
`timescale 1ns/1ps
module smcg_top_test;
  // ==========
  // Pins
  logic SYS_CLK = '0, RESETN = '0, CLK_EN = '1, XTAL_SELECTED = '1, ADC_ENABLE = '1;
  logic WDT_ENABLE = '1, BROWNOUT_ENABLE_FUSE = '1, IRQ_TWI_MATCH = '0, EXT_RESET_REQ = '0;
  logic IRQ_ANY_ENABLED = '0, IRQ_COMPARATOR = '0, IRQ_ADC_DONE = '0, IRQ_SPM_EE_READY = '0;
  logic TIMER0_OVF_EVENT = '0, TIMER0_CMP_EVENT = '0, TIMER0_OVF_IE = '0, TIMER0_CMP_IE = '0;
  logic GLOBAL_IE = '0, TIMER0_ASYNC_SELECT = '0, WDT_RESET_REQ = '0, BOD_RESET_REQ = '0;
  logic COMPARATOR_DISABLE = '0, COMPARATOR_USES_VREF = '0, ADC_CONV_STARTED = '0;
  logic [1:0] CLOCK_SELECT_FUSE = '0;
  logic [2:0] SLEEP_MODE_SELECT = '0;
  logic [3:0] LOWER_EXT_IRQ_LINES = '1, UPPER_EXT_IRQ_LINES = '1, UPPER_LEVEL_MODE = '0;
  logic [7:0] EXT_IRQ_ENABLE = '0, WAKE_PIN_BUF_EN;
  logic SLEEP_EXEC, SLEEP_ENABLE_BIT, CORE_CLOCK_EN, PROGRAM_MEM_CLOCK_EN, ASYNC_CLOCK_EN;
  logic PERIPHERAL_IO_CLOCK_EN, CONVERTER_CLOCK_EN, MAIN_OSC_EN, TIMER_OSC_EN, VREF_EN;
  logic ADC_AUTO_START, ADC_EXTENDED_NEXT, COMPARATOR_POWER_EN, BOD_ACTIVE, WDT_RUN;
  logic INPUT_BUF_EN, SLEEPING, CORE_HALT, WAKE_IRQ, WAKE_RESET, ASYNC_REGS_UNDEFINED;
  logic MODE_REFUSED, req = '0, no_en = '0;
  int   err_count = 0, num_checks = 0, cyc = 0, n;
  // Core, sleeping, io, adc, osc, auto start, refused, comparator
  logic [7:0] rows [8] = '{8'h7D, 8'h5D, 8'h40, 8'h40, 8'hBB, 8'hBB, 8'h48, 8'h48};

  smcg_top u_smcg_top (.*);
  smcg_core_model u_smcg_core_model (.clk(SYS_CLK), .req(req), .sleep_exec(SLEEP_EXEC),
    .sleep_en(SLEEP_ENABLE_BIT), .no_en(no_en));

  always #5 SYS_CLK = ~SYS_CLK;
  // Hang guard, far above the hundred or so cycles used
  always @(posedge SYS_CLK) if (++cyc > 1000) begin
    err_count++;
    conclude();
  end

  // ==========
  // Tasks
  task chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // Returns on the first falling edge after the answer edge
  task sleep_on(input logic [2:0] m);
    SLEEP_MODE_SELECT <= m;
    req <= 1'h1;
    repeat (2) @(negedge SYS_CLK);
    req <= 1'h0;
    @(negedge SYS_CLK);
  endtask
  task wake_rst;
    EXT_RESET_REQ <= 1'h1;
    @(negedge SYS_CLK);
    chk("reset wake", 8'({WAKE_RESET, SLEEPING}), 8'h02);
    EXT_RESET_REQ <= 1'h0;
  endtask
  // halt cycles counted until the handler runs
  task wait_wake(input string name, input logic [7:0] exp);
    n = 0;
    while (WAKE_IRQ !== 1'h1 && n < 40) begin
      @(negedge SYS_CLK);
      n += int'(CORE_HALT === 1'h1);
    end
    chk(name, 8'(n), exp);
    chk("wake irq", 8'({WAKE_IRQ, CORE_CLOCK_EN}), 8'h03);
  endtask
  task conclude;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // ==========
  // Sequence
  initial begin
    repeat (2) @(negedge SYS_CLK);
    RESETN <= 1'h1;
    @(negedge SYS_CLK);
    chk("after reset", 8'({CORE_CLOCK_EN, SLEEPING, INPUT_BUF_EN}), 8'h05);
    chk("ext conversion", 8'(ADC_EXTENDED_NEXT), 8'h01);
    no_en <= 1'h1;
    sleep_on(3'h0);
    chk("no enable", 8'({SLEEPING, MODE_REFUSED, CORE_CLOCK_EN}), 8'h01);
    no_en <= 1'h0;
    for (int i = 0; i < 8; i++) begin
      sleep_on(3'(i));
      chk("mode gating", {CORE_CLOCK_EN, SLEEPING, PERIPHERAL_IO_CLOCK_EN, CONVERTER_CLOCK_EN,
        MAIN_OSC_EN, ADC_AUTO_START, MODE_REFUSED, COMPARATOR_POWER_EN}, rows[i]);
      chk("input buffers", 8'(INPUT_BUF_EN), 8'(rows[i][5] | rows[i][4]));
      chk("kept alive", 8'({WDT_RUN, BOD_ACTIVE, VREF_EN}), 8'h07);
      chk("flash async timer", 8'({PROGRAM_MEM_CLOCK_EN, ASYNC_CLOCK_EN, TIMER_OSC_EN}),
        8'({rows[i][7], rows[i][4], 1'b0}));
      chk("pin buffers", WAKE_PIN_BUF_EN, {8{rows[i][5] | rows[i][4]}});
      if (rows[i][6]) wake_rst();
    end
    sleep_on(3'h6);
    IRQ_TWI_MATCH <= 1'h1;
    wait_wake("stby halt", 8'h0B);
    IRQ_TWI_MATCH <= 1'h0;
    EXT_IRQ_ENABLE <= 8'h01;
    sleep_on(3'h2);
    IRQ_ANY_ENABLED <= 1'h1;
    repeat (3) @(negedge SYS_CLK);
    chk("pdown ignores irq", 8'(SLEEPING), 8'h01);
    chk("wake pin buffers", WAKE_PIN_BUF_EN, 8'h01);
    IRQ_ANY_ENABLED <= 1'h0;
    LOWER_EXT_IRQ_LINES <= 4'hE;
    wait_wake("pdown halt", 8'h15);
    LOWER_EXT_IRQ_LINES <= 4'hF;
    sleep_on(3'h3);
    LOWER_EXT_IRQ_LINES <= 4'hE;
    wait_wake("psave halt", 8'h15);
    chk("async undefined", 8'(ASYNC_REGS_UNDEFINED), 8'h01);
    LOWER_EXT_IRQ_LINES <= 4'hF;
    COMPARATOR_DISABLE <= 1'h1;
    ADC_CONV_STARTED <= 1'h1;
    @(negedge SYS_CLK);
    ADC_CONV_STARTED <= 1'h0;
    ADC_ENABLE <= 1'h0;
    chk("conversion started", 8'(ADC_EXTENDED_NEXT), 8'h00);
    @(negedge SYS_CLK);
    ADC_ENABLE <= 1'h1;
    chk("comparator off", 8'(COMPARATOR_POWER_EN), 8'h00);
    repeat (2) @(negedge SYS_CLK);
    chk("adc re-enabled", 8'(ADC_EXTENDED_NEXT), 8'h01);
    conclude();
  end
endmodule // smcg_top_test
